// ==== common/mipt_pkg.sv ====
// Constants shared by the interrupt and time output logic
package mipt_pkg;
  // Clock and real-time clock step
  localparam int unsigned CLK_PERIOD_NS    = 4;
  localparam logic [31:0] NS_STEP          = 32'h0000_0004;
  localparam logic [31:0] NS_PER_SEC       = 32'h3B9A_CA00;
  // Periodic timer, 1/128 s expressed in ns
  localparam int unsigned TIMER_PERIOD_NS  = 1000000000 / 128;
  localparam logic [23:0] TIMER_CYCLES     = 24'(TIMER_PERIOD_NS / CLK_PERIOD_NS);
  // Eight kHz clock, 125 us period
  localparam int unsigned EIGHT_KHZ_TICK_CLOCK_PERIOD_US  = 125;
  localparam logic [23:0] EIGHT_KHZ_TICK_CLOCK_HALF_CYCLES =
    24'((EIGHT_KHZ_TICK_CLOCK_PERIOD_US * 1000) / (2 * CLK_PERIOD_NS));
  // Interrupt source positions
  localparam int unsigned SRC_MDIO         = 0;
  localparam int unsigned SRC_PTP_RX       = 1;
  localparam int unsigned SRC_PTP_TX       = 2;
  localparam int unsigned SRC_PTP_TIMER    = 3;
  localparam int unsigned SRC_COUNT        = 4;
  // Values after reset
  localparam logic [3:0]  PENDING_RESET    = 4'h0;
  localparam logic [31:0] NS_RESET         = 32'h0000_0000;
  localparam logic [47:0] SEC_RESET        = 48'h0000_0000_0000;
  localparam logic [23:0] CNT_RESET        = 24'h00_0000;
endpackage

// ==== common/mipt_time_if.sv ====
// Time base signals between the counter module and the top
`timescale 1ns/100ps
interface mipt_time_if;
  logic [31:0] ns;         // Nanoseconds field
  logic [47:0] sec;        // Seconds field
  logic [31:0] ns_1722;    // Alternate format nanoseconds
  logic        tick;       // One cycle per 1/128 s
  logic        eight_khz_tick_clock;      // Eight kHz square wave
  modport src (output ns, output sec, output ns_1722, output tick, output eight_khz_tick_clock);
  modport dst (input ns, input sec, input ns_1722, input tick, input eight_khz_tick_clock);
endinterface

// ==== rtl/mipt_time_base.sv ====
// Real-time clock counter with derived timer tick and eight kHz clock
`timescale 1ns/100ps
module mipt_time_base #(
  parameter logic [23:0] TIMER_CYCLES      = mipt_pkg::TIMER_CYCLES,
  parameter logic [23:0] EIGHT_KHZ_TICK_CLOCK_HALF_CYCLES = mipt_pkg::EIGHT_KHZ_TICK_CLOCK_HALF_CYCLES
) (
  input  wire logic        clk_in,      // System clock
  input  wire logic        reset_in,    // Synchronous reset, high
  input  wire logic        load_wr_in,  // Nanoseconds offset write
  input  wire logic [31:0] load_ns_in,  // Nanoseconds offset value
  mipt_time_if.src         time_if      // Time outputs
);

  // Last count of a divider
  function automatic logic cnt_last(input logic [23:0] cnt, input logic [23:0] limit);
    cnt_last = (cnt == limit - 24'h00_0001);
  endfunction

  logic [31:0] ns;
  logic [47:0] sec;
  logic [31:0] ns_1722;
  logic [23:0] tmr_cnt;
  logic [23:0] k_cnt;
  logic        tick;
  logic        eight_khz_tick_clock;

  //////////////////////////////////////////////////////////////////////////////
  // Next values; out-of-range offsets are ignored to keep ns below a second
  wire         ns_wrap      = (ns >= mipt_pkg::NS_PER_SEC - mipt_pkg::NS_STEP);
  wire         load_ok      = load_wr_in && (load_ns_in < mipt_pkg::NS_PER_SEC);
  wire [31:0]  next_ns      = load_ok ? load_ns_in :
                              (ns_wrap ? mipt_pkg::NS_RESET : ns + mipt_pkg::NS_STEP);
  wire [47:0]  next_sec     = (!load_ok && ns_wrap) ? sec + 48'h0000_0000_0001 : sec;
  // Alternate field follows each load of ns, but keeps counting when ns wraps at a second
  wire [31:0]  next_ns_1722 = load_ok ? ns_1722 + load_ns_in - ns
                                      : ns_1722 + mipt_pkg::NS_STEP;
  wire         tmr_last     = cnt_last(tmr_cnt, TIMER_CYCLES);
  wire         k_last       = cnt_last(k_cnt, EIGHT_KHZ_TICK_CLOCK_HALF_CYCLES);
  wire [23:0]  next_tmr_cnt = tmr_last ? mipt_pkg::CNT_RESET : tmr_cnt + 24'h00_0001;
  wire [23:0]  next_k_cnt   = k_last ? mipt_pkg::CNT_RESET : k_cnt + 24'h00_0001;

  // Clock fields
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ns      <= mipt_pkg::NS_RESET;
      sec     <= mipt_pkg::SEC_RESET;
      ns_1722 <= mipt_pkg::NS_RESET;
    end else begin
      ns      <= next_ns;
      sec     <= next_sec;
      ns_1722 <= next_ns_1722;
    end
  end

  // Dividers counting clock steps, so both lock to the clock rate
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tmr_cnt <= mipt_pkg::CNT_RESET;
      k_cnt   <= mipt_pkg::CNT_RESET;
      tick    <= 1'b0;
      eight_khz_tick_clock   <= 1'b0;
    end else begin
      tmr_cnt <= next_tmr_cnt;
      k_cnt   <= next_k_cnt;
      tick    <= tmr_last;
      eight_khz_tick_clock   <= eight_khz_tick_clock ^ k_last;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interface drive
  assign time_if.ns      = ns;
  assign time_if.sec     = sec;
  assign time_if.ns_1722 = ns_1722;
  assign time_if.tick    = tick;
  assign time_if.eight_khz_tick_clock   = eight_khz_tick_clock;

endmodule

// ==== rtl/mipt_top.sv ====
// Interrupt aggregation and precise timing outputs of the MAC
`timescale 1ns/100ps
module mipt_top #(
  parameter bit          HAS_MGMT          = 1'b1,
  parameter bit          HAS_AVB           = 1'b1,
  parameter logic [23:0] TIMER_CYCLES      = mipt_pkg::TIMER_CYCLES,
  parameter logic [23:0] EIGHT_KHZ_TICK_CLOCK_HALF_CYCLES = mipt_pkg::EIGHT_KHZ_TICK_CLOCK_HALF_CYCLES
) (
  input  wire logic        clk_in,                     // 250 MHz clock
  input  wire logic        reset_in,                   // Synchronous reset, high
  input  wire logic        mdio_done_in,               // Management transfer done pulse
  input  wire logic        ptp_rx_done_in,             // PTP packet received pulse
  input  wire logic        ptp_tx_done_in,             // PTP packet sent pulse
  input  wire logic [3:0]  irq_enable_in,              // Per-source enables
  input  wire logic [3:0]  irq_clear_in,               // Per-source clear pulses
  input  wire logic        ns_offset_wr_in,            // Nanoseconds offset write
  input  wire logic [31:0] ns_offset_in,               // Nanoseconds offset value
  output logic             mac_irq_out,                // Combined interrupt level
  output logic             ptp_rx_irq_out,             // Receive pending flag
  output logic             ptp_tx_irq_out,             // Transmit pending flag
  output logic             ptp_timer_irq_out,          // Timer pending flag
  output logic [31:0]      rtc_ns_field_out,           // Nanoseconds field
  output logic [47:0]      rtc_sec_field_out,          // Seconds field
  output logic             eight_khz_tick_clock_out,   // Eight kHz clock
  output logic [31:0]      rtc_ns_1722_field_out       // Alternate nanoseconds
);

  mipt_time_if time_bus ();

  //////////////////////////////////////////////////////////////////////////////
  // Time base; held in reset when the bridging option is absent
  wire tb_reset = reset_in || !HAS_AVB;

  mipt_time_base #(
    .TIMER_CYCLES      (TIMER_CYCLES),
    .EIGHT_KHZ_TICK_CLOCK_HALF_CYCLES (EIGHT_KHZ_TICK_CLOCK_HALF_CYCLES)
  ) u_time_base (
    .clk_in     (clk_in),
    .reset_in   (tb_reset),
    .load_wr_in (ns_offset_wr_in),
    .load_ns_in (ns_offset_in),
    .time_if    (time_bus)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Source events; PTP sources exist only with bridging
  logic [3:0] pending;
  wire  [3:0] src_event;

  assign src_event[mipt_pkg::SRC_MDIO]      = mdio_done_in;
  assign src_event[mipt_pkg::SRC_PTP_RX]    = HAS_AVB && ptp_rx_done_in;
  assign src_event[mipt_pkg::SRC_PTP_TX]    = HAS_AVB && ptp_tx_done_in;
  assign src_event[mipt_pkg::SRC_PTP_TIMER] = HAS_AVB && time_bus.tick;

  // Set wins over clear so an event in the clear cycle is kept
  wire [3:0] next_pending = (pending & ~irq_clear_in) | src_event;
  wire [3:0] active       = pending & irq_enable_in;
  wire       next_irq     = HAS_MGMT && (|active);

  // Pending flags
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pending <= mipt_pkg::PENDING_RESET;
    end else begin
      pending <= next_pending;
    end
  end

  // Interrupt outputs, registered so the host sees a clean level
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mac_irq_out       <= 1'b0;
      ptp_rx_irq_out    <= 1'b0;
      ptp_tx_irq_out    <= 1'b0;
      ptp_timer_irq_out <= 1'b0;
    end else begin
      mac_irq_out       <= next_irq;
      ptp_rx_irq_out    <= pending[mipt_pkg::SRC_PTP_RX];
      ptp_tx_irq_out    <= pending[mipt_pkg::SRC_PTP_TX];
      ptp_timer_irq_out <= pending[mipt_pkg::SRC_PTP_TIMER];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Time outputs; one register stage, so they trail the counters by a cycle
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rtc_ns_field_out         <= mipt_pkg::NS_RESET;
      rtc_sec_field_out        <= mipt_pkg::SEC_RESET;
      eight_khz_tick_clock_out <= 1'b0;
      rtc_ns_1722_field_out    <= mipt_pkg::NS_RESET;
    end else begin
      rtc_ns_field_out         <= time_bus.ns;
      rtc_sec_field_out        <= time_bus.sec;
      eight_khz_tick_clock_out <= time_bus.eight_khz_tick_clock;
      rtc_ns_1722_field_out    <= time_bus.ns_1722;
    end
  end

endmodule

// ==== verification/mipt_host.sv ====
// Host model that services the combined interrupt by clearing sources
`timescale 1ns/100ps
module mipt_host (
  input  wire logic       clk_in,    // System clock
  input  wire logic       irq_in,    // Combined interrupt
  input  wire logic       sweep_in,  // Clear everything request
  input  wire logic [3:0] delay_in,  // Service latency in cycles
  output logic      [3:0] clear_out = 4'h0  // Clear pulses
);
  int wait_cnt = 0;
  // Latency first, then a one-cycle clear; repeats while asked
  always @(negedge clk_in) begin
    clear_out <= 4'h0;
    wait_cnt <= 0;
    if ((irq_in || sweep_in) && wait_cnt >= delay_in) clear_out <= 4'hF;
    else if (irq_in || sweep_in) wait_cnt <= wait_cnt + 1;
  end
endmodule

// ==== verification/mipt_top_chk.sv ====
// Port checks for the interrupt and time output block
`timescale 1ns/100ps
module mipt_top_chk #(
  parameter logic [23:0] TIMER_CYCLES      = mipt_pkg::TIMER_CYCLES,
  parameter logic [23:0] EIGHT_KHZ_TICK_CLOCK_HALF_CYCLES = mipt_pkg::EIGHT_KHZ_TICK_CLOCK_HALF_CYCLES
) (
  input wire logic        clk_in, reset_in, ptp_rx_done_in, ptp_tx_done_in, // Clock, events
  input wire logic [3:0]  irq_enable_in, irq_clear_in,                     // Enables, clears
  input wire logic        ns_offset_wr_in, mac_irq_out, ptp_rx_irq_out,     // Load, flags
  input wire logic        ptp_tx_irq_out, ptp_timer_irq_out, eight_khz_tick_clock_out,
  input wire logic [31:0] ns_offset_in, rtc_ns_field_out, rtc_ns_1722_field_out,
  input wire logic [47:0] rtc_sec_field_out                                // Seconds
);
  localparam int HALF = int'(EIGHT_KHZ_TICK_CLOCK_HALF_CYCLES);
  localparam int TMAX = int'(TIMER_CYCLES) + 3;
  localparam logic [31:0] NS_TOP = 32'h3B9A_C9FC;
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // Two cycles free of loads, so a jump cannot hide in a step
  sequence quiet_load; !ns_offset_wr_in ##1 !ns_offset_wr_in; endsequence
  a_rx_flag_set: assert property (ptp_rx_done_in |-> ##2 ptp_rx_irq_out)
    else $error("receive flag not raised");
  a_rx_flag_clear: assert property (irq_clear_in[1] && !ptp_rx_done_in |-> ##2 !ptp_rx_irq_out)
    else $error("receive flag not cleared");
  a_tx_flag_hold: assert property (!irq_clear_in[2] ##1 ptp_tx_irq_out |=> ptp_tx_irq_out)
    else $error("transmit flag dropped without clear");
  a_irq_on: assert property (ptp_tx_done_in && irq_enable_in[2] ##1 irq_enable_in[2]
    |-> ##1 mac_irq_out) else $error("combined interrupt missing");
  a_irq_off: assert property ((irq_enable_in == 4'h0)[*3] |-> !mac_irq_out)
    else $error("combined interrupt without enable");
  a_timer_tick: assert property (irq_clear_in[3] |-> ##[1:TMAX] ptp_timer_irq_out)
    else $error("timer tick late");
  a_ns_steps: assert property (quiet_load ##1 rtc_ns_field_out != NS_TOP |=>
    rtc_ns_field_out == $past(rtc_ns_field_out) + 32'h0000_0004 && $stable(rtc_sec_field_out))
    else $error("nanoseconds step or seconds moved");
  a_sec_wrap: assert property (quiet_load ##1 rtc_ns_field_out == NS_TOP |=>
    rtc_ns_field_out == 32'h0 && rtc_sec_field_out == $past(rtc_sec_field_out) + 48'h1)
    else $error("second rollover wrong");
  a_ns_load: assert property (ns_offset_wr_in && ns_offset_in < 32'h3B9A_CA00 ##1 !ns_offset_wr_in
    |-> ##1 rtc_ns_field_out == $past(ns_offset_in, 2)) else $error("load not seen");
  a_alt_step: assert property (quiet_load ##1 1'b1 |=>
    rtc_ns_1722_field_out == $past(rtc_ns_1722_field_out) + 32'h0000_0004)
    else $error("alternate field out of step");
  a_eight_khz_tick_clock_half: assert property ($rose(eight_khz_tick_clock_out) |-> ##HALF
    $fell(eight_khz_tick_clock_out)) else $error("eight kHz half period wrong");
endmodule
bind mipt_top mipt_top_chk #(.TIMER_CYCLES(TIMER_CYCLES),
  .EIGHT_KHZ_TICK_CLOCK_HALF_CYCLES(EIGHT_KHZ_TICK_CLOCK_HALF_CYCLES)) mipt_top_chk_i (.*);

// ==== verification/mipt_top_tb.sv ====
// Self-checking bench for the interrupt and time output block
`timescale 1ns/100ps
module mipt_top_tb;
  logic        clk_in = 0, reset_in = 1, mdio_done_in = 0, ptp_rx_done_in = 0;
  logic        ptp_tx_done_in = 0, ns_offset_wr_in = 0, sweep = 0, mac_irq_out;
  logic        ptp_rx_irq_out, ptp_tx_irq_out, ptp_timer_irq_out, eight_khz_tick_clock_out;
  logic [3:0]  irq_enable_in = 4'h0, irq_clear_in, host_delay = 4'h0;
  logic [31:0] ns_offset_in = 32'h0, rtc_ns_field_out, rtc_ns_1722_field_out;
  logic [47:0] rtc_sec_field_out;
  int          num_errors = 0, comparisons = 0, cycles = 0;
  int unsigned src, v;
  mipt_top #(.TIMER_CYCLES(24'h00_0014), .EIGHT_KHZ_TICK_CLOCK_HALF_CYCLES(24'h00_0005)) mipt_top_i (.*);
  mipt_host mipt_host_i (.clk_in(clk_in), .irq_in(mac_irq_out), .sweep_in(sweep),
    .delay_in(host_delay), .clear_out(irq_clear_in));
  always #2 clk_in = ~clk_in;
  task automatic cyc(int n); repeat (n) @(negedge clk_in); endtask
  task automatic chk(string what, logic [47:0] exp, logic [47:0] got);
    comparisons++;
    if (exp !== got) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done;
    if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    void'($urandom(32'h3ADB_F7A8));
    cyc(4);
    reset_in = 0;
    cyc(3);
    // Random sources and enables; timer left disabled so the sum is known
    for (int i = 0; i < 10; i++) begin
      src = $urandom;
      host_delay = 4'($urandom % 4);
      irq_enable_in = {1'b0, src[5:3]};
      {ptp_tx_done_in, ptp_rx_done_in, mdio_done_in} = src[2:0];
      cyc(1);
      {ptp_tx_done_in, ptp_rx_done_in, mdio_done_in} = 3'h0;
      cyc(1);
      chk("rx flag", 48'(src[1]), 48'(ptp_rx_irq_out));
      chk("tx flag", 48'(src[2]), 48'(ptp_tx_irq_out));
      chk("irq", 48'(|(src[2:0] & src[5:3])), 48'(mac_irq_out));
      sweep = 1;
      cyc(8);
      sweep = 0;
      irq_enable_in = 4'h0;
      cyc(4);
      chk("cleared", 48'h0, 48'({ptp_rx_irq_out, ptp_tx_irq_out, mac_irq_out}));
    end
    // Timer alone, slow host so the flag stays up
    irq_enable_in = 4'h8;
    host_delay = 4'hF;
    v = 0;
    while (ptp_timer_irq_out !== 1'b1 && v < 30) begin
      cyc(1);
      v++;
    end
    cyc(2);
    chk("timer flag", 48'h1, 48'(ptp_timer_irq_out));
    chk("timer irq", 48'h1, 48'(mac_irq_out));
    irq_enable_in = 4'h0;
    // Valid load then an out-of-range one, which must be ignored
    v = ($urandom % 249_999_000) * 4;
    ns_offset_wr_in = 1;
    ns_offset_in = v;
    cyc(1);
    ns_offset_in = 32'hFFFF_FFFF;
    cyc(1);
    ns_offset_wr_in = 0;
    chk("ns load", 48'(v), 48'(rtc_ns_field_out));
    // Alternate field equals ns until the first rollover, so it follows the load
    chk("alt load", 48'(v), 48'(rtc_ns_1722_field_out));
    cyc(5);
    chk("ns step", 48'(v + 20), 48'(rtc_ns_field_out));
    chk("alt step", 48'(v + 20), 48'(rtc_ns_1722_field_out));
    // Load just under one second to force the rollover
    ns_offset_wr_in = 1;
    ns_offset_in = 32'h3B9A_C9F4;
    cyc(1);
    ns_offset_wr_in = 0;
    cyc(3);
    chk("sec before", 48'h0, rtc_sec_field_out);
    cyc(1);
    chk("ns wrap", 48'h0, 48'(rtc_ns_field_out));
    chk("sec after", 48'h1, rtc_sec_field_out);
    // Alternate field keeps counting through the second boundary
    chk("alt wrap", 48'h0000_3B9A_CA00, 48'(rtc_ns_1722_field_out));
    // Eight kHz clock: find a rising edge, then five cycles high
    v = 0;
    while (eight_khz_tick_clock_out !== 1'b0 && v < 12) begin
      cyc(1);
      v++;
    end
    while (eight_khz_tick_clock_out !== 1'b1 && v < 24) begin
      cyc(1);
      v++;
    end
    cyc(4);
    chk("8k high", 48'h1, 48'(eight_khz_tick_clock_out));
    cyc(1);
    chk("8k low", 48'h0, 48'(eight_khz_tick_clock_out));
    cyc(20);
    test_done();
  end
endmodule
